/* File: dupc_top.sv */
// Pin control for the two channels of a dual UART, with APB registers.
// Assumes a 20 MHz clock; core side signals synchronous to it.
`timescale 1ns/1ns
`include "dupc_defines.svh"
module dupc_top #(
	parameter int GRP_W = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DUPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Channel A core and pins
	input wire logic chan_a_core_tx,
	input wire logic chan_a_rx_ready,
	output logic chan_a_core_rx,
	input wire logic chan_a_serial_in,
	output logic chan_a_serial_out,
	output logic chan_a_send_request_n,
	// Channel B core and pins
	input wire logic chan_b_core_tx,
	input wire logic chan_b_rx_ready,
	output logic chan_b_core_rx,
	input wire logic chan_b_serial_in,
	output logic chan_b_serial_out,
	output logic chan_b_send_request_n,
	// Shared pins, group one (modem inputs of channel A)
	input wire logic [GRP_W-1:0] grp1_pin_in,
	output logic [GRP_W-1:0] grp1_pin_out,
	output logic [GRP_W-1:0] grp1_pin_oe,
	output logic [GRP_W-1:0] grp1_modem_in,
	output logic chan_a_ring_indicator,
	// Shared pins, group two (modem inputs of channel B)
	input wire logic [GRP_W-1:0] grp2_pin_in,
	output logic [GRP_W-1:0] grp2_pin_out,
	output logic [GRP_W-1:0] grp2_pin_oe,
	output logic [GRP_W-1:0] grp2_modem_in,
	// Prog io levels seen by the core
	output logic [2*GRP_W-1:0] prog_io_in
);
	initial begin
		if (GRP_W < 1 || GRP_W > 8)
			$error("GRP_W must be 1 to 8");
	end

	localparam int IO_W = 2 * GRP_W;

	logic [7:0] mcr_a_ff, mcr_b_ff, efr_a_ff, efr_b_ff, ioctl_ff;
	logic [IO_W-1:0] io_out_ff, io_dir_ff;
	logic [31:0] nxt_prdata;
	logic setup;
	logic access;
	logic wr;
	logic hit;
	logic grp1_io;
	logic grp2_io;
	logic [IO_W-1:0] io_pins;
	dupc_pkg::dupc_chan_cfg_t cfg_a, cfg_b;
	dupc_pkg::dupc_chan_pins_t pins_a, pins_b;
	logic [IO_W-1:0] nxt_oe;

	function automatic dupc_pkg::dupc_chan_cfg_t chan_cfg(
		input logic [7:0] modem_ctrl_reg,
		input logic [7:0] enhanced_features_reg
	);
		dupc_pkg::dupc_chan_cfg_t c;
		c.loopback = modem_ctrl_reg[`DUPC_MCR_LOOP_BIT];
		c.rts_bit = modem_ctrl_reg[`DUPC_MCR_RTS_BIT];
		c.auto_rts = enhanced_features_reg[`DUPC_EFR_ARTS_BIT];
		return c;
	endfunction

	// Zero wait state: answer in the access phase
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr = access & pready & pwrite;
	assign hit = (paddr == `DUPC_OFF_MCR_A) | (paddr == `DUPC_OFF_MCR_B) |
		(paddr == `DUPC_OFF_EFR_A) | (paddr == `DUPC_OFF_EFR_B) |
		(paddr == `DUPC_OFF_IOCTL) | (paddr == `DUPC_OFF_PINS);

	assign grp1_io = ~ioctl_ff[`DUPC_IOC_GRP1_BIT];
	assign grp2_io = ~ioctl_ff[`DUPC_IOC_GRP2_BIT];
	assign io_pins = {grp2_pin_in, grp1_pin_in};
	assign nxt_oe = io_dir_ff &
		{{GRP_W{grp2_io}}, {GRP_W{grp1_io}}};

	assign cfg_a = chan_cfg(mcr_a_ff, efr_a_ff);
	assign cfg_b = chan_cfg(mcr_b_ff, efr_b_ff);

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			`DUPC_OFF_MCR_A: nxt_prdata[7:0] = mcr_a_ff;
			`DUPC_OFF_MCR_B: nxt_prdata[7:0] = mcr_b_ff;
			`DUPC_OFF_EFR_A: nxt_prdata[7:0] = efr_a_ff;
			`DUPC_OFF_EFR_B: nxt_prdata[7:0] = efr_b_ff;
			`DUPC_OFF_IOCTL: nxt_prdata[7:0] = ioctl_ff;
			`DUPC_OFF_PINS: nxt_prdata[IO_W-1:0] = io_pins;
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// Writes commit at the access edge, where the master sees pready
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mcr_a_ff <= `DUPC_MCR_RST;
			mcr_b_ff <= `DUPC_MCR_RST;
			efr_a_ff <= `DUPC_EFR_RST;
			efr_b_ff <= `DUPC_EFR_RST;
			ioctl_ff <= `DUPC_IOC_RST;
		end else if (wr) begin
			if (paddr == `DUPC_OFF_MCR_A)
				mcr_a_ff <= pwdata[7:0];
			if (paddr == `DUPC_OFF_MCR_B)
				mcr_b_ff <= pwdata[7:0];
			if (paddr == `DUPC_OFF_EFR_A)
				efr_a_ff <= pwdata[7:0];
			if (paddr == `DUPC_OFF_EFR_B)
				efr_b_ff <= pwdata[7:0];
			if (paddr == `DUPC_OFF_IOCTL)
				ioctl_ff <= pwdata[7:0];
		end
	end

	// Pin register: low half output levels, high half directions
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			io_out_ff <= '0;
			io_dir_ff <= '0;
		end else if (wr && paddr == `DUPC_OFF_PINS) begin
			io_out_ff <= pwdata[IO_W-1:0];
			io_dir_ff <= pwdata[16+IO_W-1:16];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit;
			prdata <= (setup & ~pwrite) ? nxt_prdata : 32'h0000_0000;
		end
	end

	// Modem inputs idle high when the group is used as plain io
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			grp1_pin_out <= '0;
			grp1_pin_oe <= '0;
			grp2_pin_out <= '0;
			grp2_pin_oe <= '0;
			grp1_modem_in <= '1;
			grp2_modem_in <= '1;
			chan_a_ring_indicator <= 1'b1;
			prog_io_in <= '0;
		end else begin
			grp1_pin_out <= io_out_ff[GRP_W-1:0];
			grp2_pin_out <= io_out_ff[IO_W-1:GRP_W];
			grp1_pin_oe <= nxt_oe[GRP_W-1:0];
			grp2_pin_oe <= nxt_oe[IO_W-1:GRP_W];
			grp1_modem_in <= grp1_io ? '1 : grp1_pin_in;
			grp2_modem_in <= grp2_io ? '1 : grp2_pin_in;
			chan_a_ring_indicator <= grp1_io ? 1'b1 :
				grp1_pin_in[GRP_W-1];
			prog_io_in <= io_pins;
		end
	end

	dupc_chan_pins u_chan_a (
		.clock(clock),
		.rstn(rstn),
		.cfg(cfg_a),
		.core_tx(chan_a_core_tx),
		.core_rx_ready(chan_a_rx_ready),
		.core_rx(chan_a_core_rx),
		.pin_rx(chan_a_serial_in),
		.pins(pins_a)
	);

	dupc_chan_pins u_chan_b (
		.clock(clock),
		.rstn(rstn),
		.cfg(cfg_b),
		.core_tx(chan_b_core_tx),
		.core_rx_ready(chan_b_rx_ready),
		.core_rx(chan_b_core_rx),
		.pin_rx(chan_b_serial_in),
		.pins(pins_b)
	);

	assign chan_a_serial_out = pins_a.serial_out;
	assign chan_a_send_request_n = pins_a.send_request_n;
	assign chan_b_serial_out = pins_b.serial_out;
	assign chan_b_send_request_n = pins_b.send_request_n;
endmodule

/* File: dupc_defines.svh */
// Register map, field positions and reset values for the UART pin control.
// Assumes APB with 32-bit data; each register is one aligned word.
`ifndef DUPC_DEFINES_SVH
`define DUPC_DEFINES_SVH

`define DUPC_ADDR_W 8
`define DUPC_OFF_MCR_A 8'h00
`define DUPC_OFF_MCR_B 8'h04
`define DUPC_OFF_EFR_A 8'h08
`define DUPC_OFF_EFR_B 8'h0c
`define DUPC_OFF_IOCTL 8'h10
`define DUPC_OFF_PINS 8'h14

`define DUPC_MCR_RTS_BIT 1
`define DUPC_MCR_LOOP_BIT 4
`define DUPC_EFR_ARTS_BIT 6
`define DUPC_IOC_GRP1_BIT 1
`define DUPC_IOC_GRP2_BIT 2

`define DUPC_MCR_RST 8'h00
`define DUPC_EFR_RST 8'h00
`define DUPC_IOC_RST 8'h00

`endif

/* File: dupc_pkg.sv */
// Types shared by the pin control block.
// Assumes dupc_defines.svh is compiled alongside.
package dupc_pkg;
	typedef struct packed {
		logic loopback;
		logic rts_bit;
		logic auto_rts;
	} dupc_chan_cfg_t;

	typedef struct packed {
		logic serial_out;
		logic send_request_n;
	} dupc_chan_pins_t;
endpackage

/* File: dupc_chan_pins.sv */
// Pin steering for one serial channel: loopback and send request.
// Assumes inputs synchronous to clock; outputs are registered.
`timescale 1ns/1ns
module dupc_chan_pins (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Configuration
	input wire dupc_pkg::dupc_chan_cfg_t cfg,
	// Core side
	input wire logic core_tx,
	input wire logic core_rx_ready,
	output logic core_rx,
	// Pins
	input wire logic pin_rx,
	output dupc_pkg::dupc_chan_pins_t pins
);
	logic nxt_core_rx;
	logic nxt_tx;
	logic nxt_rts_n;
	logic rts_active;

	assign nxt_core_rx = cfg.loopback ? core_tx : pin_rx;
	// Idle line level keeps the far end quiet during loopback
	assign nxt_tx = cfg.loopback ? 1'b1 : core_tx;
	// Auto mode also needs receiver room before asserting
	assign rts_active = cfg.rts_bit &
		(~cfg.auto_rts | core_rx_ready);
	assign nxt_rts_n = ~rts_active;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			core_rx <= 1'b1;
			pins.serial_out <= 1'b1;
			pins.send_request_n <= 1'b1;
		end else begin
			core_rx <= nxt_core_rx;
			pins.serial_out <= nxt_tx;
			pins.send_request_n <= nxt_rts_n;
		end
	end
endmodule

/* File: dupc_top_checker.sv */
// Assertions on the pin control top ports.
// Assumes one clock; rstn asynchronous, active low.
`timescale 1ns/1ns
module dupc_top_checker #(
	parameter int GRP_W = 4
) (
	// Clock, reset, APB
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic chan_a_core_tx,
	input wire logic chan_a_core_rx,
	input wire logic chan_a_serial_in,
	input wire logic chan_a_serial_out,
	input wire logic chan_a_send_request_n,
	input wire logic [GRP_W-1:0] grp1_pin_in,
	input wire logic [GRP_W-1:0] grp1_pin_oe,
	input wire logic [GRP_W-1:0] grp1_modem_in,
	input wire logic chan_a_ring_indicator
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	property p_rst; $rose(rstn) |-> chan_a_send_request_n; endproperty
	a_rst: assert property (p_rst) else $error("rts");
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("ans");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("one");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("err");
	// Core data differing from the pin means loopback is on
	property p_ltx; $past(rstn) && chan_a_core_rx != $past(chan_a_serial_in)
		|-> chan_a_serial_out; endproperty
	a_ltx: assert property (p_ltx) else $error("ltx");
	property p_lrx; $past(rstn) && chan_a_core_rx != $past(chan_a_serial_in)
		|-> chan_a_core_rx == $past(chan_a_core_tx); endproperty
	a_lrx: assert property (p_lrx) else $error("lrx");
	property p_grp; grp1_modem_in != '1 |-> grp1_pin_oe == '0
		&& grp1_modem_in == $past(grp1_pin_in); endproperty
	a_grp: assert property (p_grp) else $error("grp");
	property p_ri; chan_a_ring_indicator == grp1_modem_in[GRP_W-1]; endproperty
	a_ri: assert property (p_ri) else $error("ri");
endmodule

/* File: dupc_remote_model.sv */
// Remote serial device: receive lines and shared pin levels.
// Assumes free-running levels, no handshake with the block.
`timescale 1ns/1ns
module dupc_remote_model (
	// Clock
	input wire logic clock,
	// Toward the block
	output logic [1:0] line,
	output logic [7:0] pins
);
	logic [7:0] lfsr = 8'h5a;
	// Shifts every cycle so a stale sample of pins never matches by luck; the two line bits can repeat
	always @(posedge clock)
		lfsr <= {lfsr[6:0], ^(lfsr & 8'hb8)};
	assign line = lfsr[2:1];
	assign pins = lfsr ^ 8'h3c;
endmodule

/* File: dupc_top_tb.sv */
// Bench for the pin control: random register setups and pin traffic.
// Assumes the remote model drives receive lines and shared pins.
`timescale 1ns/1ns
module dupc_top_tb;
	logic clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, ring, err;
	logic [7:0] paddr = 8'h00, pins, sp, gm, r[5] = '{default: 8'h00};
	logic [7:0] m[5] = '{8'h12, 8'h12, 8'h40, 8'h40, 8'h06};
	logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h4def145b;
	logic [1:0] tx = 2'h0, rdy = 2'h0, crx, sout, rts, line, stx, srdy, sin;
	int fail_count = 0, n_compared = 0, j, k, q;
	logic [7:0] po, poe, pio;
	logic [31:0] pv = 32'h0;
	dupc_top i_dupc_top (.clock(clock), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_a_core_tx(tx[0]), .chan_a_rx_ready(rdy[0]),
		.chan_a_core_rx(crx[0]), .chan_a_serial_in(line[0]),
		.chan_a_serial_out(sout[0]), .chan_a_send_request_n(rts[0]),
		.chan_b_core_tx(tx[1]), .chan_b_rx_ready(rdy[1]),
		.chan_b_core_rx(crx[1]), .chan_b_serial_in(line[1]),
		.chan_b_serial_out(sout[1]), .chan_b_send_request_n(rts[1]),
		.grp1_pin_in(pins[3:0]), .grp1_pin_out(po[3:0]),
		.grp1_pin_oe(poe[3:0]),
		.grp1_modem_in(gm[3:0]), .chan_a_ring_indicator(ring),
		.grp2_pin_in(pins[7:4]), .grp2_pin_out(po[7:4]),
		.grp2_pin_oe(poe[7:4]),
		.grp2_modem_in(gm[7:4]), .prog_io_in(pio));
	dupc_remote_model i_dupc_remote_model (.clock(clock), .line(line),
		.pins(pins));
	initial begin
		forever #25 clock = ~clock;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// r: send ctl A, B, features A, B, pin function
	function automatic logic [7:0] exp_ch(input int c);
		return {5'h00, ~(r[c][1] & (~r[c+2][6] | srdy[c])),
			r[c][4] | stx[c], r[c][4] ? stx[c] : sin[c]};
	endfunction
	function automatic logic [7:0] exp_gm();
		return {r[4][2] ? sp[7:4] : 4'hf, r[4][1] ? sp[3:0] : 4'hf};
	endfunction
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never sees pready
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic run(input int n);
		for (k = 0; k < n; k++) begin
			@(posedge clock);
			if (k > 0) begin
				chk("a", exp_ch(0), {5'h00, rts[0], sout[0], crx[0]});
				chk("b", exp_ch(1), {5'h00, rts[1], sout[1], crx[1]});
				chk("gm", exp_gm(), gm);
				chk("ri", {7'h00, r[4][1] ? sp[3] : 1'h1}, {7'h00, ring});
				chk("po", pv[7:0], po);
				chk("oe", pv[23:16] & {r[4][2] ? 4'h0 : 4'hf,
					r[4][1] ? 4'h0 : 4'hf}, poe);
				chk("pio", sp, pio);
			end
			stx = tx;
			srdy = rdy;
			sin = line;
			sp = pins;
			v = rnd();
			tx <= v[1:0];
			rdy <= v[3:2];
		end
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'h1;
		chk("rst", 8'h03, {6'h00, rts});
		for (j = 0; j < 40; j++) begin
			q = j % 6;
			v = rnd();
			if (q == 5) begin
				pv = v & 32'h00ff00ff;
				apb(1'h1, 8'h14, pv);
			end else begin
				r[q] = v[7:0] & m[q];
				apb(1'h1, 8'(4 * q), {24'h0, r[q]});
			end
			run(4);
		end
		apb(1'h0, 8'h00, 32'h0);
		chk("rd", r[0], rd[7:0]);
		chk("rderr", 8'h00, {7'h00, err});
		apb(1'h0, 8'h20, 32'h0);
		chk("bad", 8'h01, {6'h00, |rd, err});
		r[0] = 8'h02;
		r[2] = 8'h00;
		apb(1'h1, 8'h00, 32'h2);
		apb(1'h1, 8'h08, 32'h0);
		run(3);
		rstn <= 1'h0;
		@(posedge clock);
		chk("rst2", 8'h03, {6'h00, rts});
		rstn <= 1'h1;
		r = '{default: 8'h00};
		pv = 32'h0;
		run(6);
		finish_test();
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule
bind dupc_top dupc_top_checker #(.GRP_W(GRP_W)) i_dupc_top_checker (.*);
